//--- rtl/zcd_top.sv
// Zero-cross detector control, edge detection and interrupt flag.
//
// Our own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ns
module zcd_top
(
  input wire logic CLK_SYS,
  input wire logic RESETN,
  input wire logic [2:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic COMP_SINK,
  input wire logic CFG_FUSE_SET,
  input wire logic PIN_OUT_NORMAL,
  input wire logic PIN_OE_NORMAL,
  output logic PIN_OUT,
  output logic PIN_OE,
  output logic ANALOG_ACTIVE,
  output logic LEVEL_OUT,
  output logic IRQ
);
  // ****************************************
  // Synchronised comparator decision.
  // ****************************************
  logic sink_s;

  zcd_sync u_sync
  (
    .clk(CLK_SYS),
    .rst_n(RESETN),
    .d(COMP_SINK),
    .q(sink_s)
  );

  // ****************************************
  // Register state.
  // ****************************************
  logic en_r, en_nxt;
  logic pol_r, pol_nxt;
  logic rise_r, rise_nxt;
  logic fall_r, fall_nxt;
  logic flag_r, flag_nxt;
  logic ie_r, ie_nxt;
  logic gie_r, gie_nxt;
  logic peripheral_irq_enable_r, peripheral_irq_enable_nxt;
  logic fuse_r, fuse_nxt;
  logic fuse_done_r, fuse_done_nxt;
  logic lvl_r, lvl_nxt;
  logic [7:0] rdata_nxt;
  logic irq_nxt, pin_out_nxt, pin_oe_nxt, active_nxt;
  logic active, lvl, rise_ev, fall_ev, set_ev;

  function automatic logic hit(input logic [2:0] a, input logic [2:0] target, input logic s);
    hit = s && (a == target);
  endfunction

  always_comb
  begin
    fuse_nxt = fuse_r;
    fuse_done_nxt = 1'b1;
    if (!fuse_done_r)
    begin
      fuse_nxt = CFG_FUSE_SET;
    end
    active = !fuse_r || en_r;
    lvl = sink_s ^ pol_r;
    lvl_nxt = lvl;
    rise_ev = lvl && !lvl_r;
    fall_ev = !lvl && lvl_r;
    set_ev = (rise_ev && rise_r) || (fall_ev && fall_r);
    en_nxt = en_r;
    pol_nxt = pol_r;
    rise_nxt = rise_r;
    fall_nxt = fall_r;
    flag_nxt = flag_r;
    ie_nxt = ie_r;
    gie_nxt = gie_r;
    peripheral_irq_enable_nxt = peripheral_irq_enable_r;
    if (hit(ADDR, zcd_pkg::ZCD_ADDR_CTRL, WR))
    begin
      en_nxt = WDATA[zcd_pkg::CTRL_EN];
      pol_nxt = WDATA[zcd_pkg::CTRL_POL];
      rise_nxt = WDATA[zcd_pkg::CTRL_RISE];
      fall_nxt = WDATA[zcd_pkg::CTRL_FALL];
    end
    if (hit(ADDR, zcd_pkg::ZCD_ADDR_FLAGS, WR))
    begin
      flag_nxt = WDATA[zcd_pkg::FLAG_BIT];
    end
    if (set_ev)
    begin
      flag_nxt = 1'b1;
    end
    if (hit(ADDR, zcd_pkg::ZCD_ADDR_ENABLES, WR))
    begin
      ie_nxt = WDATA[zcd_pkg::IE_BIT];
    end
    if (hit(ADDR, zcd_pkg::ZCD_ADDR_IRQCTL, WR))
    begin
      gie_nxt = WDATA[zcd_pkg::GIE_BIT];
      peripheral_irq_enable_nxt = WDATA[zcd_pkg::PERIPHERAL_IRQ_ENABLE_BIT];
    end
    rdata_nxt = 8'h00;
    if (RD)
    begin
      case (ADDR)
        zcd_pkg::ZCD_ADDR_CTRL:
        begin
          rdata_nxt[zcd_pkg::CTRL_EN] = en_r;
          rdata_nxt[zcd_pkg::CTRL_OUT] = lvl_r;
          rdata_nxt[zcd_pkg::CTRL_POL] = pol_r;
          rdata_nxt[zcd_pkg::CTRL_RISE] = rise_r;
          rdata_nxt[zcd_pkg::CTRL_FALL] = fall_r;
        end
        zcd_pkg::ZCD_ADDR_FLAGS: rdata_nxt[zcd_pkg::FLAG_BIT] = flag_r;
        zcd_pkg::ZCD_ADDR_ENABLES: rdata_nxt[zcd_pkg::IE_BIT] = ie_r;
        zcd_pkg::ZCD_ADDR_IRQCTL:
        begin
          rdata_nxt[zcd_pkg::GIE_BIT] = gie_r;
          rdata_nxt[zcd_pkg::PERIPHERAL_IRQ_ENABLE_BIT] = peripheral_irq_enable_r;
        end
        default: rdata_nxt = 8'h00;
      endcase
    end
    // Sleep has no input here, so operation continues unchanged.
    irq_nxt = flag_nxt && ie_nxt && peripheral_irq_enable_nxt && gie_nxt;
    pin_out_nxt = active ? 1'b0 : PIN_OUT_NORMAL;
    pin_oe_nxt = active ? 1'b0 : PIN_OE_NORMAL;
    active_nxt = active;
  end

  always_ff @(posedge CLK_SYS or negedge RESETN)
  begin
    if (!RESETN)
    begin
      en_r <= 1'b0;
      pol_r <= 1'b0;
      rise_r <= 1'b0;
      fall_r <= 1'b0;
      flag_r <= 1'b0;
      ie_r <= 1'b0;
      gie_r <= 1'b0;
      peripheral_irq_enable_r <= 1'b0;
      fuse_r <= 1'b1;
      fuse_done_r <= 1'b0;
      lvl_r <= 1'b0;
      RDATA <= zcd_pkg::ZCD_RESET_BYTE;
      IRQ <= 1'b0;
      PIN_OUT <= 1'b0;
      PIN_OE <= 1'b0;
      ANALOG_ACTIVE <= 1'b0;
      LEVEL_OUT <= 1'b0;
    end
    else
    begin
      en_r <= en_nxt;
      pol_r <= pol_nxt;
      rise_r <= rise_nxt;
      fall_r <= fall_nxt;
      flag_r <= flag_nxt;
      ie_r <= ie_nxt;
      gie_r <= gie_nxt;
      peripheral_irq_enable_r <= peripheral_irq_enable_nxt;
      fuse_r <= fuse_nxt;
      fuse_done_r <= fuse_done_nxt;
      lvl_r <= lvl_nxt;
      RDATA <= rdata_nxt;
      IRQ <= irq_nxt;
      PIN_OUT <= pin_out_nxt;
      PIN_OE <= pin_oe_nxt;
      ANALOG_ACTIVE <= active_nxt;
      LEVEL_OUT <= lvl_nxt;
    end
  end

  // ****************************************
  // Checks.
  // ****************************************
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);

  flag_sticky_a: assert property (flag_r && !hit(ADDR, zcd_pkg::ZCD_ADDR_FLAGS, WR) |=> flag_r)
    else $error("Flag cleared without software write.");
  set_wins_a: assert property (set_ev |=> flag_r)
    else $error("Enabled edge lost.");
  rise_set_a: assert property (rise_ev && rise_r |=> flag_r)
    else $error("Rise did not set flag.");
  fall_set_a: assert property (fall_ev && fall_r |=> flag_r)
    else $error("Fall did not set flag.");
  no_spurious_a: assert property (!flag_r && !set_ev && !WR |=> !flag_r)
    else $error("Flag set without enabled edge.");
  irq_gate_a: assert property (IRQ |-> $past(flag_nxt) && ie_r && gie_r && peripheral_irq_enable_r)
    else $error("Interrupt without all enables.");
  level_map_a: assert property (##1 LEVEL_OUT == ($past(sink_s) ^ $past(pol_r)))
    else $error("Level polarity wrong.");
  pin_force_a: assert property (active |=> !PIN_OE)
    else $error("Pin not released to analog.");
  pol_edge_a: assert property (hit(ADDR, zcd_pkg::ZCD_ADDR_CTRL, WR) && !pol_r
    && WDATA[zcd_pkg::CTRL_POL] && WDATA[zcd_pkg::CTRL_RISE] && !sink_s ##1 !sink_s
    |=> flag_r)
    else $error("Polarity change made no edge.");
  rise_cov: cover property (rise_ev && rise_r);
  fall_cov: cover property (fall_ev && fall_r);
  irq_cov: cover property (IRQ);
  clash_cov: cover property (set_ev && hit(ADDR, zcd_pkg::ZCD_ADDR_FLAGS, WR));
endmodule

//--- rtl/zcd_pkg.sv
// Constants and register map for the zero-cross detector logic.
package zcd_pkg;
  localparam logic [2:0] ZCD_ADDR_CTRL = 3'h0;
  localparam logic [2:0] ZCD_ADDR_FLAGS = 3'h1;
  localparam logic [2:0] ZCD_ADDR_ENABLES = 3'h2;
  localparam logic [2:0] ZCD_ADDR_IRQCTL = 3'h3;
  localparam int CTRL_EN = 7;
  localparam int CTRL_OUT = 5;
  localparam int CTRL_POL = 4;
  localparam int CTRL_RISE = 1;
  localparam int CTRL_FALL = 0;
  localparam int FLAG_BIT = 4;
  localparam int IE_BIT = 4;
  localparam int GIE_BIT = 7;
  localparam int PERIPHERAL_IRQ_ENABLE_BIT = 6;
  localparam logic [7:0] ZCD_RESET_BYTE = 8'h00;
endpackage

//--- rtl/zcd_sync.sv
// Two-flop synchroniser for the asynchronous comparator decision.
`timescale 1ns/1ns
module zcd_sync
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic d,
  output logic q
);
  logic s1_r;
  logic s2_r;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
    end
    else
    begin
      s1_r <= d;
      s2_r <= s1_r;
    end
  end

  assign q = s2_r;
endmodule

//--- test/zcd_ac_source.sv
// Behavioural AC source seen through the series resistor, as a comparator decision.
`timescale 1ns/1ns
module zcd_ac_source
(
  input wire logic run,
  input wire logic hold_level,
  output logic comp_sink
);
  logic osc = 1'b0;
  // Free-running swing unrelated to the system clock; no pull-up biases the pin.
  always #53 osc = ~osc;
  // Sinking while above the threshold, sourcing below it.
  assign comp_sink = run ? osc : hold_level;
endmodule

//--- test/zero_cross_detect_logic_tb.sv
// Self-checking bench for the zero-cross detector logic.
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin err_total++; \
  $display("mismatch %s exp %h got %h", nm, ex, got); end end
module zero_cross_detect_logic_tb;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic run = 1'b0;
  logic hold_level = 1'b0;
  logic fuse_set = 1'b1;
  logic pin_out_normal = 1'b1;
  logic pin_oe_normal = 1'b1;
  logic [7:0] rdata;
  logic comp_sink;
  logic pin_out;
  logic pin_oe;
  logic analog_active;
  logic level_out;
  logic irq;
  int err_total = 0;
  int samples_checked = 0;
  int cycles = 0;
  initial forever #4 clk_sys = ~clk_sys;
  zcd_ac_source src (.run(run), .hold_level(hold_level), .comp_sink(comp_sink));
  zcd_top uut (.CLK_SYS(clk_sys), .RESETN(resetn), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .COMP_SINK(comp_sink), .CFG_FUSE_SET(fuse_set),
    .PIN_OUT_NORMAL(pin_out_normal), .PIN_OE_NORMAL(pin_oe_normal), .PIN_OUT(pin_out),
    .PIN_OE(pin_oe),
    .ANALOG_ACTIVE(analog_active), .LEVEL_OUT(level_out), .IRQ(irq));
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      err_total++;
      complete_run();
    end
  end
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] ex, input string nm);
    @(posedge clk_sys);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1;
    `CHK(nm, ex, rdata)
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic t_reset();
    rd_chk(3'h0, 8'h00, "ctrl reset");
    `CHK("active", 1'b0, analog_active)
    `CHK("pin oe", 1'b1, pin_oe)
    `CHK("pin out", 1'b1, pin_out)
    rd_chk(3'h5, 8'h00, "unmapped");
  endtask
  task automatic t_level();
    hold_level <= 1'b1;
    wr_reg(3'h0, 8'h80);
    wait_cyc(4);
    #1;
    `CHK("active", 1'b1, analog_active)
    `CHK("pin oe", 1'b0, pin_oe)
    `CHK("level", 1'b1, level_out)
    rd_chk(3'h0, 8'hA0, "ctrl sink");
    wr_reg(3'h0, 8'h90);
    wait_cyc(4);
    #1;
    `CHK("level inv", 1'b0, level_out)
    rd_chk(3'h1, 8'h00, "flag gated");
  endtask
  task automatic t_edges();
    wr_reg(3'h3, 8'hC0);
    wr_reg(3'h2, 8'h10);
    wr_reg(3'h0, 8'h82);
    wait_cyc(4);
    wr_reg(3'h1, 8'h00);
    hold_level <= 1'b0;
    wait_cyc(6);
    rd_chk(3'h1, 8'h00, "fall ignored");
    `CHK("irq idle", 1'b0, irq)
    hold_level <= 1'b1;
    wait_cyc(6);
    rd_chk(3'h1, 8'h10, "rise flag");
    `CHK("irq", 1'b1, irq)
    wr_reg(3'h3, 8'h80);
    wait_cyc(2);
    #1;
    `CHK("irq peripheral_irq_enable off", 1'b0, irq)
    wr_reg(3'h3, 8'hC0);
    wr_reg(3'h1, 8'h00);
  endtask
  task automatic t_pol();
    hold_level <= 1'b0;
    wr_reg(3'h0, 8'h02);
    wait_cyc(4);
    wr_reg(3'h1, 8'h00);
    wr_reg(3'h0, 8'h12);
    wr_reg(3'h0, 8'h02);
    wait_cyc(4);
    rd_chk(3'h1, 8'h10, "pol edge");
    wait_cyc(30);
    rd_chk(3'h1, 8'h10, "flag held");
    wait_cyc(1);
    pin_out_normal <= 1'b0;
    pin_oe_normal <= 1'b0;
    wait_cyc(2);
    #1;
    `CHK("pin out follow", 1'b0, pin_out)
    `CHK("pin oe follow", 1'b0, pin_oe)
    wait_cyc(1);
    pin_out_normal <= 1'b1;
    pin_oe_normal <= 1'b1;
  endtask
  task automatic t_race();
    wr_reg(3'h0, 8'h83);
    wait_cyc(4);
    wr_reg(3'h1, 8'h00);
    hold_level <= ~hold_level;
    wait_cyc(1);
    wr_reg(3'h1, 8'h00);
    wait_cyc(2);
    rd_chk(3'h1, 8'h10, "set wins");
  endtask
  task automatic t_run();
    wr_reg(3'h1, 8'h00);
    run <= 1'b1;
    wait_cyc(100);
    rd_chk(3'h1, 8'h10, "ac flag");
    `CHK("ac irq", 1'b1, irq)
    run <= 1'b0;
  endtask
  task automatic t_fuse();
    wait_cyc(1);
    fuse_set <= 1'b0;
    resetn <= 1'b0;
    wait_cyc(2);
    resetn <= 1'b1;
    wait_cyc(3);
    #1;
    `CHK("fuse active", 1'b1, analog_active)
    `CHK("fuse pin oe", 1'b0, pin_oe)
    wr_reg(3'h0, 8'h00);
    wait_cyc(2);
    #1;
    `CHK("fuse en ignored", 1'b1, analog_active)
  endtask
  initial
  begin
    wait_cyc(5);
    resetn <= 1'b1;
    t_reset();
    t_level();
    t_edges();
    t_pol();
    t_race();
    t_run();
    t_fuse();
    complete_run();
  end
endmodule
